/* File: include/pin_front_regs.svh */
// Register offsets, field positions, reset values and timing counts of the control-pin front end.
// Assumes a 4-bit byte address on the register port and 32-bit data.
`ifndef PIN_FRONT_REGS_SVH
`define PIN_FRONT_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_IRQ_CLR 4'h8

// ****************************************
// Control field positions and reset value
// ****************************************
`define CTRL_IRQ_EDGE_LSB 0
`define CTRL_ACK_MODE_LSB 4
`define CTRL_SLAVE_BIT 6
`define CTRL_TIN_EDGE_LSB 7
`define CTRL_TOUT_CONT_LSB 9
`define CTRL_WIDTH 11
`define CTRL_RESET 11'h000

// ****************************************
// Status field positions
// ****************************************
`define ST_RESET_OUT 0
`define ST_FETCH_GO 1
`define ST_WAITING 2
`define ST_NMI_PEND 3
`define ST_IRQ_LSB 4
`define ST_DMA_LSB 8
`define ST_TIN_LSB 10
`define ST_TEST 12

// ****************************************
// Timing and encodings
// ****************************************
`define STARTUP_CYC 3'h7
`define STATUS_INACTIVE 3'h7
`define NMI_TYPE 8'h02
`define SYNC_W 11

`endif

/* File: include/pin_front_pkg.sv */
// Types shared by the control-pin front end.
// Assumes nothing beyond a SystemVerilog compiler.
package pin_front_pkg;

  typedef enum logic [1:0] {PH_HOLD_INACT, PH_HOLD_TRI, PH_STARTUP, PH_RUN} rst_phase_e;

  typedef struct packed {
    logic [1:0] tout_cont;
    logic [1:0] tin_edge;
    logic slave_mode;
    logic [1:0] ack_mode;
    logic [3:0] irq_edge;
  } ctrl_s;

  typedef struct packed {
    logic [1:0] dma_req;
    logic [1:0] timer_gate;
    logic [1:0] timer_count;
  } sync_pins_s;

endpackage : pin_front_pkg

/* File: core/sync2.sv */
// Two-flop synchroniser for a vector of unrelated level inputs.
// Assumes each bit is sampled independently; no word coherence.
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : sync2

/* File: core/clk_div2.sv */
// Divide-by-two of the oscillator clock with a processor-clock enable.
// Assumes mclk is the oscillator; the divided clock is an output only, never a clock inside.
module clk_div2 (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Divided clock
  output logic divided_clock_out,
  output logic pclk_en
);

  logic div_nxt;

  always_comb begin
    div_nxt = ~divided_clock_out;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divided_clock_out <= 1'b0;
    end else begin
      divided_clock_out <= div_nxt;
    end
  end

  // The enable marks the mclk edge on which the divided clock rises.
  assign pclk_en = ~divided_clock_out;

endmodule : clk_div2

/* File: core/cpu_control_pin_front_end.sv */
// Control-pin front end: clock division, system reset, wait-for-test, timers, DMA and interrupt pins.
// Assumes mclk is the oscillator input and the core logic uses pclk_en as its clock enable.
// Behaviour
// R1: Reset output high, clock aligned, tracks input.
// R2: Output clock is oscillator divided by two.
// R3: Output clock square, fifty percent duty.
// R4: Reset input low clears logic, stays dormant.
// R5: Reset input synchronised; held low over four.
// R6: Fetching starts seven clocks after release.
// R7: Reset released no sooner than 50 us.
// R8: Status lines inactive one clock, then floated.
// R9: Test high at wait suspends until low.
// R10: Interrupts serviced during wait; test synchronised.
// R11: Timer inputs count rising edges or gate.
// R12: Timer outputs pulse once or run continuously.
// R13: DMA requests level, active high, synchronised.
// R14: Rising non-maskable input raises type two.
// R15: Non-maskable latched, taken at instruction boundary.
// R16: Requests active high; pins 2,3 become acks.
// R17: Each maskable input edge or level triggered.
// R18: Source holds request until acknowledged.
// R19: Slave-controller mode redefines interrupt pin roles.
// R20: All asynchronous inputs pass two flip-flops.
`include "pin_front_regs.svh"

module cpu_control_pin_front_end (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Reset and clock pins
  input wire logic system_init_in_n,
  output logic reset_out,
  output logic divided_clock_out,
  // Wait, timer and DMA pins
  input wire logic test_in,
  input wire logic timer_in0,
  input wire logic timer_in1,
  output logic timer_out0,
  output logic timer_out1,
  input wire logic dma_req_ch0,
  input wire logic dma_req_ch1,
  // Interrupt pins
  input wire logic nmi_in,
  input wire logic irq0_in,
  input wire logic irq1_in,
  input wire logic irq2_or_ack0_in,
  output logic irq2_or_ack0_out,
  output logic irq2_or_ack0_oe,
  input wire logic irq3_or_ack1_in,
  output logic irq3_or_ack1_out,
  output logic irq3_or_ack1_oe,
  // Bus status pins
  output logic [2:0] bus_status_out,
  output logic bus_status_oe,
  // Core side
  output logic pclk_en,
  input wire logic [2:0] core_status,
  output logic fetch_go,
  input wire logic wait_start,
  input wire logic int_enable,
  output logic waiting,
  output logic wait_resume,
  input wire logic instr_boundary,
  output logic nmi_take,
  output logic [7:0] nmi_type,
  input wire logic [3:0] irq_ack,
  input wire logic [1:0] inta_in,
  output logic [3:0] irq_pending,
  output logic service_req,
  input wire logic [1:0] timer_expire,
  output pin_front_pkg::sync_pins_s pins_sync,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import pin_front_pkg::*;

  // ****************************************
  // Clock division and input synchronisers
  // ****************************************
  logic [`SYNC_W-1:0] raw_in;
  logic [`SYNC_W-1:0] sync_q;
  logic [`SYNC_W-1:0] sync_prev_r;
  logic rst_s;
  logic test_s;
  logic nmi_s;
  logic [3:0] irq_s;
  logic [3:0] irq_rise;
  logic [1:0] tin_s;
  logic [1:0] tin_rise;
  logic nmi_rise;

  clk_div2 u_div (  // R2 R3
    .mclk(mclk),
    .arst_n(arst_n),
    .divided_clock_out(divided_clock_out),
    .pclk_en(pclk_en)
  );

  assign raw_in = {system_init_in_n, test_in, timer_in1, timer_in0, dma_req_ch1, dma_req_ch0,
                   nmi_in, irq3_or_ack1_in, irq2_or_ack0_in, irq1_in, irq0_in};

  sync2 #(.W(`SYNC_W)) u_sync (  // R5 R10 R11 R13 R16 R20
    .mclk(mclk),
    .arst_n(arst_n),
    .d(raw_in),
    .q(sync_q)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_prev_r <= '0;
    end else begin
      sync_prev_r <= sync_q;
    end
  end

  assign rst_s = sync_q[10];
  assign test_s = sync_q[9];
  assign tin_s = sync_q[8:7];
  assign nmi_s = sync_q[4];
  assign irq_s = sync_q[3:0];
  assign tin_rise = sync_q[8:7] & ~sync_prev_r[8:7];
  assign nmi_rise = nmi_s & ~sync_prev_r[4];  // R14
  assign irq_rise = sync_q[3:0] & ~sync_prev_r[3:0];
  assign pins_sync.dma_req = sync_q[6:5];  // R13
  assign pins_sync.timer_gate = tin_s;

  // ****************************************
  // Reset sequencing
  // ****************************************
  rst_phase_e phase_r, phase_nxt;
  logic [2:0] start_cnt_r, start_cnt_nxt;
  logic reset_out_nxt;

  always_comb begin
    phase_nxt = phase_r;
    start_cnt_nxt = start_cnt_r;
    reset_out_nxt = reset_out;
    if (pclk_en) begin
      reset_out_nxt = ~rst_s;  // R1
    end
    case (phase_r)
      PH_HOLD_INACT: begin
        if (pclk_en) begin
          phase_nxt = PH_HOLD_TRI;  // R8
        end
      end
      PH_HOLD_TRI: begin
        start_cnt_nxt = 3'h0;
        if (rst_s && pclk_en) begin
          phase_nxt = PH_STARTUP;
        end
      end
      PH_STARTUP: begin
        if (pclk_en) begin
          if (start_cnt_r == `STARTUP_CYC - 3'h1) begin
            phase_nxt = PH_RUN;  // R6
          end else begin
            start_cnt_nxt = start_cnt_r + 3'h1;
          end
        end
      end
      PH_RUN: begin
        phase_nxt = PH_RUN;
      end
      default: begin
        phase_nxt = PH_HOLD_INACT;
      end
    endcase
    // Reset drops the startup and run phases at once, without waiting for the processor clock.
    if (!rst_s && (phase_r == PH_STARTUP || phase_r == PH_RUN)) begin
      phase_nxt = PH_HOLD_INACT;  // R4
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= PH_HOLD_INACT;
      start_cnt_r <= 3'h0;
      reset_out <= 1'b1;
    end else begin
      phase_r <= phase_nxt;
      start_cnt_r <= start_cnt_nxt;
      reset_out <= reset_out_nxt;
    end
  end

  assign fetch_go = (phase_r == PH_RUN);
  assign bus_status_oe = (phase_r == PH_HOLD_INACT) || (phase_r == PH_RUN);  // R8
  assign bus_status_out = (phase_r == PH_RUN) ? core_status : `STATUS_INACTIVE;

  // ****************************************
  // Wait-for-test and non-maskable request
  // ****************************************
  logic waiting_nxt;
  logic nmi_pend_r, nmi_pend_nxt;
  logic nmi_take_nxt;

  always_comb begin
    waiting_nxt = waiting;
    nmi_pend_nxt = nmi_pend_r;
    nmi_take_nxt = 1'b0;
    if (wait_start && test_s) begin
      waiting_nxt = 1'b1;  // R9
    end else if (waiting && !test_s) begin
      waiting_nxt = 1'b0;  // R9
    end
    if (instr_boundary && nmi_pend_r) begin
      nmi_take_nxt = 1'b1;  // R15
      nmi_pend_nxt = 1'b0;
    end
    // A new edge in the cycle the old one is taken stays pending.
    if (nmi_rise) begin
      nmi_pend_nxt = 1'b1;  // R14 R15
    end
    if (!rst_s) begin
      waiting_nxt = 1'b0;  // R4
      nmi_pend_nxt = 1'b0;
      nmi_take_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      waiting <= 1'b0;
      nmi_pend_r <= 1'b0;
      nmi_take <= 1'b0;
    end else begin
      waiting <= waiting_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      nmi_take <= nmi_take_nxt;
    end
  end

  assign wait_resume = waiting && !test_s;
  assign nmi_type = `NMI_TYPE;  // R14
  // Interrupts are offered to the core while it waits on the test input.
  assign service_req = nmi_pend_r || (int_enable && (|irq_pending));  // R10

  // ****************************************
  // Maskable interrupt pins
  // ****************************************
  ctrl_s ctrl_r, ctrl_nxt;
  logic [3:0] irq_nxt;
  logic [3:0] irq_clr;
  logic [3:0] pin_is_in;

  always_comb begin
    irq_clr = irq_ack;
    if (reg_wr && reg_addr == `ADDR_IRQ_CLR) begin
      irq_clr = irq_clr | reg_wdata[3:0];
    end
    pin_is_in = {~ctrl_r.ack_mode[1], ~ctrl_r.ack_mode[0], 2'b11};  // R16
    irq_nxt = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (ctrl_r.irq_edge[i]) begin
        // Set wins over clear so an edge in the acknowledge cycle survives.
        irq_nxt[i] = (irq_pending[i] & ~irq_clr[i]) | irq_rise[i];  // R17
      end else begin
        irq_nxt[i] = irq_s[i];  // R17 R18
      end
    end
    irq_nxt = irq_nxt & pin_is_in;
    // The slave controller owns pin 0 as a level request; the other pins carry no request.
    if (ctrl_r.slave_mode) begin
      irq_nxt = {3'b000, irq_s[0]};  // R19
    end
    if (!rst_s) begin
      irq_nxt = 4'h0;  // R4
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_pending <= 4'h0;
    end else begin
      irq_pending <= irq_nxt;
    end
  end

  assign irq2_or_ack0_oe = ctrl_r.ack_mode[0] || ctrl_r.slave_mode;  // R16 R19
  assign irq2_or_ack0_out = ~inta_in[0];
  assign irq3_or_ack1_oe = ctrl_r.ack_mode[1] && !ctrl_r.slave_mode;  // R16
  assign irq3_or_ack1_out = ~inta_in[1];

  // ****************************************
  // Timer pins
  // ****************************************
  logic [1:0] tout_nxt;
  logic [1:0] tcnt_nxt;
  logic [1:0] tcnt_r;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // Gate-mode timers see no count pulses, only the level.
      tcnt_nxt[i] = ctrl_r.tin_edge[i] & tin_rise[i];  // R11
      if (ctrl_r.tout_cont[i]) begin
        tout_nxt[i] = timer_expire[i] ? ~(i == 0 ? timer_out0 : timer_out1)
                                      : (i == 0 ? timer_out0 : timer_out1);  // R12
      end else begin
        tout_nxt[i] = timer_expire[i];  // R12
      end
    end
    if (!rst_s) begin
      tout_nxt = 2'b00;
      tcnt_nxt = 2'b00;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_out0 <= 1'b0;
      timer_out1 <= 1'b0;
      tcnt_r <= 2'b00;
    end else begin
      timer_out0 <= tout_nxt[0];
      timer_out1 <= tout_nxt[1];
      tcnt_r <= tcnt_nxt;
    end
  end

  // The count pulses live in their own register so that the output struct has no procedural writer.
  assign pins_sync.timer_count = tcnt_r;  // R11

  // ****************************************
  // Register port
  // ****************************************
  logic [31:0] rdata_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr && reg_addr == `ADDR_CTRL) begin
      ctrl_nxt = reg_wdata[`CTRL_WIDTH-1:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL: rdata_nxt = {21'h000000, ctrl_r};
        `ADDR_STATUS: begin
          rdata_nxt[`ST_RESET_OUT] = reset_out;
          rdata_nxt[`ST_FETCH_GO] = fetch_go;
          rdata_nxt[`ST_WAITING] = waiting;
          rdata_nxt[`ST_NMI_PEND] = nmi_pend_r;
          rdata_nxt[`ST_IRQ_LSB +: 4] = irq_pending;
          rdata_nxt[`ST_DMA_LSB +: 2] = pins_sync.dma_req;
          rdata_nxt[`ST_TIN_LSB +: 2] = tin_s;
          rdata_nxt[`ST_TEST] = test_s;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `CTRL_RESET;
      reg_rdata <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_reset_out_follow: assert property (pclk_en && !rst_s |=> reset_out)  // R1
    else $error("reset output not raised while reset input low");
  chk_clock_toggles: assert property (1 |=> divided_clock_out != $past(divided_clock_out))  // R2 R3
    else $error("divided clock failed to toggle");
  chk_core_cleared: assert property (!rst_s |=> !waiting && !nmi_pend_r && irq_pending == 4'h0)  // R4
    else $error("core state not cleared under reset");
  chk_startup_hold: assert property ($rose(rst_s) ##1 rst_s [*8] |-> !fetch_go)  // R6
    else $error("fetch started too early after reset release");
  chk_startup_done: assert property ($rose(phase_r == PH_STARTUP) ##1 rst_s [*8] |-> ##[1:8] fetch_go)  // R6
    else $error("fetch not started after startup delay");
  chk_status_inactive: assert property ($fell(rst_s) |=> bus_status_oe && bus_status_out == `STATUS_INACTIVE
                                        ##2 !bus_status_oe)  // R8
    else $error("status lines not inactive then floated on reset");
  chk_wait_resume: assert property (waiting && !test_s && rst_s |=> !waiting)  // R9
    else $error("wait not ended when test went low");
  chk_nmi_latched: assert property (nmi_rise && rst_s |=> nmi_pend_r)  // R14 R15
    else $error("non-maskable edge not latched");
  chk_edge_held: assert property (ctrl_r.irq_edge[1] && !ctrl_r.slave_mode && irq_pending[1] && !irq_clr[1]
                                  && rst_s && $stable(ctrl_r) |=> irq_pending[1])  // R17
    else $error("edge request lost before acknowledge");
  chk_ack_drive: assert property (ctrl_r.ack_mode[0] && !ctrl_r.slave_mode |-> irq2_or_ack0_oe
                                  && irq2_or_ack0_out == !inta_in[0] && !irq_nxt[2])  // R16
    else $error("acknowledge output not driven active low");
  chk_tout_toggle: assert property (ctrl_r.tout_cont[0] && timer_expire[0] && rst_s
                                    |=> timer_out0 != $past(timer_out0))  // R12
    else $error("continuous timer output did not toggle");

  cov_nmi_taken: cover property (nmi_rise ##[1:20] nmi_take);
  cov_wait_resume: cover property (wait_start && test_s ##[1:50] wait_resume);
  cov_startup: cover property ($rose(rst_s) ##[1:30] fetch_go);

endmodule : cpu_control_pin_front_end

/* File: verification/sys_env_model.sv */
// Far-side model: power-on reset network, one interrupt source and one DMA requester.
// Assumes the bench gives its commands as levels sampled on rising mclk.
module sys_env_model (
  // Clock
  input wire logic mclk,
  // Commands from the bench
  input wire logic pulse_go,
  input wire logic [7:0] pulse_len,
  input wire logic irq_raise,
  input wire logic irq_ackd,
  input wire logic dma_want,
  // Pins toward the device
  output logic system_init_in_n,
  output logic irq_line,
  output logic dma_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // The power-on hold is 50 us at 20 MHz; releasing sooner leaves the device uninitialised.
  localparam int POR_CYC = 1000;
  int cnt = POR_CYC;
  initial begin
    system_init_in_n = 1'b0;
    irq_line = 1'b0;
    dma_line = 1'b0;
  end
  always @(posedge mclk) begin
    if (pulse_go) begin
      cnt <= (pulse_len > 8'h0A) ? int'(pulse_len) : 10;
      system_init_in_n <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= 0;
      system_init_in_n <= 1'b1;
    end
    if (irq_raise) begin
      irq_line <= 1'b1;
    end else if (irq_ackd) begin
      irq_line <= 1'b0;
    end
    dma_line <= dma_want;
  end
endmodule : sys_env_model

/* File: verification/tb.sv */
// Self-checking bench for the control-pin front end: pins, core side and register port.
// Assumes the far-side model drives the reset pin, interrupt pin 0 and DMA channel 0.
`include "pin_front_regs.svh"

`define CHECK_EQ(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_front_pkg::*;
  // **********
  // Signals
  // **********
  localparam int CEIL = 4000;
  localparam logic [3:0][31:0] CFG = {32'h40, 32'h30, 32'h10, 32'h0};
  localparam logic [3:0][1:0] OE = {2'b10, 2'b11, 2'b10, 2'b00};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic test_in, timer_in0, timer_in1, dma_req_ch1, nmi_in, irq1_in, wait_start, int_enable;
  logic instr_boundary, reg_wr, reg_rd, pulse_go, irq_raise, dma_want, init_n, irq0_line, dma0_line;
  logic reset_out, divided_clock_out, timer_out0, timer_out1, pclk_en, fetch_go, waiting;
  logic irq2_or_ack0_in, irq2_or_ack0_out, irq2_or_ack0_oe, irq3_or_ack1_in, irq3_or_ack1_out;
  logic irq3_or_ack1_oe, bus_status_oe, wait_resume, nmi_take, service_req, prev, seen;
  logic [7:0] pulse_len, nmi_type;
  logic [2:0] core_status, bus_status_out;
  logic [3:0] irq_ack, reg_addr, irq_pending;
  logic [1:0] inta_in, timer_expire;
  logic [31:0] reg_wdata, reg_rdata, rd;
  sync_pins_s pins_sync;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int hi_prev = 0;
  int n;
  always #25 mclk = ~mclk;
  // Open-drain style pins: the device wins while it drives, otherwise the board pulls low.
  assign irq2_or_ack0_in = irq2_or_ack0_oe ? irq2_or_ack0_out : 1'b0;
  assign irq3_or_ack1_in = irq3_or_ack1_oe ? irq3_or_ack1_out : 1'b0;
  sys_env_model env_u (.mclk, .pulse_go, .pulse_len, .irq_raise, .irq_ackd(irq_ack[0]), .dma_want,
    .system_init_in_n(init_n), .irq_line(irq0_line), .dma_line(dma0_line));
  cpu_control_pin_front_end dut_u (.mclk, .arst_n, .system_init_in_n(init_n), .reset_out,
    .divided_clock_out, .test_in, .timer_in0, .timer_in1, .timer_out0, .timer_out1,
    .dma_req_ch0(dma0_line), .dma_req_ch1, .nmi_in, .irq0_in(irq0_line), .irq1_in,
    .irq2_or_ack0_in, .irq2_or_ack0_out, .irq2_or_ack0_oe, .irq3_or_ack1_in, .irq3_or_ack1_out,
    .irq3_or_ack1_oe, .bus_status_out, .bus_status_oe, .pclk_en, .core_status, .fetch_go,
    .wait_start, .int_enable, .waiting, .wait_resume, .instr_boundary, .nmi_take, .nmi_type,
    .irq_ack, .inta_in, .irq_pending, .service_req, .timer_expire, .pins_sync, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // **********
  // Tasks
  // **********
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick
  task automatic look(input int k);
    tick(k);
    #1;
  endtask : look
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    tick(1);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    tick(1);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    tick(1);
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick(1);
    reg_rd <= 1'b0;
    #1;
    `CHECK_EQ(reg_rdata & mask, exp)
  endtask : reg_read
  task automatic test_done(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_errors);
  endtask : test_done
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic sys_reset(input int len);
    int hi;
    int ni;
    hi = 0;
    ni = 0;
    tick(1);
    pulse_len <= 8'(len);
    pulse_go <= 1'b1;
    tick(1);
    pulse_go <= 1'b0;
    for (int i = 0; i < len + 30; i++) begin
      look(1);
      hi += int'(reset_out === 1'b1);
      ni += int'(bus_status_oe === 1'b1 && bus_status_out === `STATUS_INACTIVE);
      if (i == 8) begin
        `CHECK_EQ({fetch_go, waiting, bus_status_oe}, 3'h0)
      end
    end
    `CHECK_EQ(hi[0], 1'b0)
    if (hi_prev != 0) begin
      `CHECK_EQ(hi - hi_prev inside {[28:32]}, 1'b1)
    end
    hi_prev = hi;
    `CHECK_EQ(ni inside {[1:2]}, 1'b1)
    `CHECK_EQ(fetch_go, 1'b1)
  endtask : sys_reset
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      n_errors++;
      end_of_test();
    end
  end
  // **********
  // Sequence
  // **********
  initial begin
    {test_in, timer_in0, timer_in1, dma_req_ch1, nmi_in, irq1_in, wait_start, int_enable} = '0;
    {instr_boundary, reg_wr, reg_rd, pulse_go, irq_raise, dma_want, pulse_len, irq_ack} = '0;
    {reg_addr, inta_in, timer_expire, reg_wdata} = '0;
    core_status = 3'h5;
    tick(7);
    #1;
    `CHECK_EQ({bus_status_oe, bus_status_out, reset_out}, 5'h1F)
    tick(1);
    arst_n <= 1'b1;
    look(4);
    `CHECK_EQ({reset_out, fetch_go, bus_status_oe}, 3'h4)
    reg_read(`ADDR_CTRL, 32'hFFFFFFFF, {21'h0, `CTRL_RESET});
    reg_read(`ADDR_STATUS, 32'h3, 32'h1);
    reg_read(4'hC, 32'hFFFFFFFF, 32'h0);
    reg_write(`ADDR_CTRL, 32'hFFFFFFFF);
    reg_read(`ADDR_CTRL, 32'hFFFFFFFF, 32'h7FF);
    reg_write(`ADDR_CTRL, 32'h0);
    test_done("register reset values");
    n = 0;
    while (init_n !== 1'b1 && n < 1200) begin
      look(1);
      n++;
    end
    n = 0;
    while (fetch_go !== 1'b1 && n < 40) begin
      look(1);
      n++;
    end
    `CHECK_EQ(n inside {[14:20]}, 1'b1)
    `CHECK_EQ({reset_out, bus_status_oe, bus_status_out}, {2'b01, core_status})
    test_done("startup");
    prev = divided_clock_out;
    for (int i = 0; i < 16; i++) begin
      look(1);
      `CHECK_EQ(divided_clock_out, ~prev)
      `CHECK_EQ(pclk_en, ~divided_clock_out)
      prev = divided_clock_out;
    end
    test_done("clock division");
    tick(1);
    test_in <= 1'b1;
    int_enable <= 1'b1;
    tick(4);
    wait_start <= 1'b1;
    tick(1);
    wait_start <= 1'b0;
    irq_raise <= 1'b1;
    tick(1);
    irq_raise <= 1'b0;
    look(5);
    `CHECK_EQ({waiting, service_req}, 2'b11)
    tick(1);
    irq_ack[0] <= 1'b1;
    test_in <= 1'b0;
    int_enable <= 1'b0;
    tick(1);
    irq_ack[0] <= 1'b0;
    n = 0;
    seen = 1'b0;
    while (waiting !== 1'b0 && n < 8) begin
      look(1);
      seen |= wait_resume;
      n++;
    end
    `CHECK_EQ({seen, n inside {[2:4]}}, 2'b11)
    test_done("wait for test");
    tick(1);
    nmi_in <= 1'b1;
    tick(2);
    nmi_in <= 1'b0;
    look(4);
    `CHECK_EQ(service_req, 1'b1)
    reg_read(`ADDR_STATUS, 32'h8, 32'h8);
    tick(1);
    instr_boundary <= 1'b1;
    tick(1);
    instr_boundary <= 1'b0;
    #1;
    `CHECK_EQ({nmi_take, nmi_type}, {1'b1, `NMI_TYPE})
    look(1);
    `CHECK_EQ({nmi_take, service_req}, 2'b00)
    test_done("non-maskable");
    for (int m = 0; m < 2; m++) begin
      reg_write(`ADDR_CTRL, 32'(m) << (`CTRL_IRQ_EDGE_LSB + 1));
      irq1_in <= 1'b1;
      look(5);
      `CHECK_EQ(irq_pending[1], 1'b1)
      tick(1);
      irq1_in <= 1'b0;
      look(5);
      `CHECK_EQ(irq_pending[1], 1'(m))
      reg_write(`ADDR_IRQ_CLR, 32'h2);
      look(1);
      `CHECK_EQ(irq_pending[1], 1'b0)
    end
    test_done("edge and level");
    tick(1);
    inta_in <= 2'b01;
    for (int k = 0; k < 4; k++) begin
      reg_write(`ADDR_CTRL, CFG[k]);
      look(1);
      `CHECK_EQ({irq2_or_ack0_oe, irq3_or_ack1_oe, irq2_or_ack0_out, irq3_or_ack1_out}, {OE[k], 2'b01})
    end
    tick(1);
    irq1_in <= 1'b1;
    look(5);
    `CHECK_EQ(irq_pending, 4'h0)
    tick(1);
    irq1_in <= 1'b0;
    test_done("pin roles");
    tick(1);
    dma_want <= 1'b1;
    dma_req_ch1 <= 1'b1;
    look(1);
    `CHECK_EQ(pins_sync.dma_req[1], 1'b0)
    look(10);
    `CHECK_EQ(pins_sync.dma_req, 2'b11)
    reg_read(`ADDR_STATUS, 32'h300, 32'h300);
    tick(1);
    dma_want <= 1'b0;
    dma_req_ch1 <= 1'b0;
    look(5);
    `CHECK_EQ(pins_sync.dma_req, 2'b00)
    test_done("dma requests");
    reg_write(`ADDR_CTRL, 32'h280);
    timer_in0 <= 1'b1;
    timer_in1 <= 1'b1;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      look(1);
      n += int'(pins_sync.timer_count[0] === 1'b1);
    end
    `CHECK_EQ(n, 1)
    `CHECK_EQ({pins_sync.timer_gate[1], pins_sync.timer_count[1]}, 2'b10)
    prev = timer_out0;
    for (int i = 0; i < 2; i++) begin
      tick(1);
      timer_expire <= 2'b11;
      tick(1);
      timer_expire <= 2'b00;
      #1;
      `CHECK_EQ({timer_out0, timer_out1}, {~prev, 1'b1})
      look(1);
      `CHECK_EQ({timer_out0, timer_out1}, {~prev, 1'b0})
      prev = timer_out0;
    end
    test_done("timers");
    tick(1);
    test_in <= 1'b1;
    tick(4);
    wait_start <= 1'b1;
    tick(1);
    wait_start <= 1'b0;
    sys_reset(10);
    sys_reset(40);
    test_done("system reset");
    end_of_test();
  end
endmodule : tb
